//--- logic/qrb_mem.sv
/*
 * Storage of the burst SRAM: four arrays, one per word position of a burst,
 * each written with per-lane masks and read with a registered output.
 * Assumes the caller never reads and writes the same burst in one cycle.
 */
`timescale 1ns/100ps

module qrb_mem (
    input wire logic i_clk,
    input wire logic i_we,
    input wire logic [qrb_pkg::ADDR_W-1:0] i_waddr,
    input wire logic [qrb_pkg::BURST_W-1:0] i_wdata,
    input wire logic [qrb_pkg::BURST_LEN*qrb_pkg::LANES-1:0] i_wmask,
    input wire logic i_re,
    input wire logic [qrb_pkg::ADDR_W-1:0] i_raddr,
    output logic [qrb_pkg::BURST_W-1:0] o_rdata
);

    // ------------------------------------------------------------------
    // One array per burst position, so word k of a burst lives in array k at entry A.
    // ------------------------------------------------------------------
    for (genvar k = 0; k < qrb_pkg::BURST_LEN; k++) begin : g_arr
        logic [qrb_pkg::WORD_W-1:0] arr [0:(1<<qrb_pkg::ADDR_W)-1];
        logic [qrb_pkg::WORD_W-1:0] rd_ff;

        // Lane writes leave a masked lane untouched; reads are registered.
        always_ff @(posedge i_clk) begin
            if (i_we && i_wmask[2*k]) begin
                arr[i_waddr][qrb_pkg::LANE0_MSB:0] <=
                    i_wdata[k*qrb_pkg::WORD_W +: qrb_pkg::LANE1_LSB];
            end
            if (i_we && i_wmask[2*k+1]) begin
                arr[i_waddr][qrb_pkg::WORD_W-1:qrb_pkg::LANE1_LSB] <=
                    i_wdata[k*qrb_pkg::WORD_W+qrb_pkg::LANE1_LSB +:
                            qrb_pkg::WORD_W-qrb_pkg::LANE1_LSB];
            end
            if (i_re) begin
                rd_ff <= arr[i_raddr];
            end
        end

        // Each array's registered word feeds its own slot of the read burst.
        assign o_rdata[k*qrb_pkg::WORD_W +: qrb_pkg::WORD_W] = rd_ff;
    end

endmodule : qrb_mem

//--- logic/qrb_pkg.sv
/*
 * Shared constants and types for the burst SRAM port logic: word and address
 * widths, burst length, byte-lane split and the beat timing of both ports.
 * Assumes one reference clock on which every beat is one clock cycle.
 */
package qrb_pkg;

    // ------------------------------------------------------------------
    // Widths and organisation.
    // ------------------------------------------------------------------
    localparam int ADDR_W = 20;
    localparam int WORD_W = 18;
    localparam int BURST_LEN = 4;
    localparam int BURST_W = WORD_W * BURST_LEN;
    localparam int LANES = 2;
    localparam int LANE0_MSB = 8;
    localparam int LANE1_LSB = 9;

    // ------------------------------------------------------------------
    // Beat timing, counted in reference clock cycles from acceptance.
    // ------------------------------------------------------------------
    localparam logic [1:0] RD_LAT_PLL = 2'h3;
    localparam logic [1:0] RD_LAT_LEGACY = 2'h2;
    localparam logic [1:0] OUT_WORDS_LEFT = 2'h3;
    localparam int WR_AGE_DEPTH = 5;
    localparam int RD_AGE_DEPTH = 3;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    // ------------------------------------------------------------------
    // Reset values.
    // ------------------------------------------------------------------
    localparam logic [WORD_W-1:0] Q_RESET = 18'h00000;

    // Read latency modes chosen by the strap.
    typedef enum logic {
        QRB_MODE_PLL,
        QRB_MODE_LEGACY
    } qrb_mode_t;

endpackage : qrb_pkg

//--- logic/qrb_ports.sv
/*
 * Read and write port logic of a pipelined four-word burst SRAM with one
 * shared address bus. Each reference clock cycle is one beat: beats with
 * o_k_phase low stand for positive input clock rises, the others for
 * negative input clock rises; read data leaves on the same beat grid.
 * Assumes all pins come from outside the clock domain and are synchronised.
 */
// Function
// - Strap high: first word 1.5 cycles later.
// - Strap low: legacy single-cycle read latency.
// - Transactions start only on positive clock rise.
// - Write data captured on both clock rises.
// - Read data launched from output registers.
// - Selects and lane enables registered on rises.
// - Every access is four 18-bit words.
// - Read select latches address into read register.
// - Words leave lowest first, one per beat.
// - Back-to-back read request is ignored.
// - Alternate-cycle reads stream without gaps.
// - Deselected read finishes, then outputs float.
// - Write select starts write with address.
// - Four words then commit all 72 bits.
// - Back-to-back write request is discarded.
// - Alternate-cycle writes accept every beat.
// - Deselected write finishes, then ignores inputs.
// - Lane enables sampled with every word.
// - Disabled lane keeps its stored contents.
// - Read and write share one address bus.
// - Selects sampled only on positive rise.
// - Both selected from idle: read first, alternate.
// - Burst order is A, A+1, A+2, A+3; here the four words go to four arrays, all at entry A.
`timescale 1ns/100ps

module qrb_ports (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_read_port_select_n,
    input wire logic i_write_port_select_n,
    input wire logic [qrb_pkg::ADDR_W-1:0] i_addr,
    input wire logic [qrb_pkg::WORD_W-1:0] i_d,
    input wire logic [qrb_pkg::LANES-1:0] i_byte_lane_enable_n,
    input wire logic i_pll_disable_n,
    output logic o_k_phase,
    output logic [qrb_pkg::WORD_W-1:0] o_q,
    output logic o_q_oe
);

    // ------------------------------------------------------------------
    // Pin synchronisers.
    // ------------------------------------------------------------------
    localparam int PIN_W = 3 + qrb_pkg::ADDR_W + qrb_pkg::WORD_W + qrb_pkg::LANES;
    logic [PIN_W-1:0] pin_meta_ff;
    logic [PIN_W-1:0] pin_sync_ff;
    logic rsel_n;
    logic wsel_n;
    logic strap_n;
    logic [qrb_pkg::ADDR_W-1:0] addr;
    logic [qrb_pkg::WORD_W-1:0] din;
    logic [qrb_pkg::LANES-1:0] lane_n;

    // Two flip-flops per pin; selects and strap reset high, lane enables reset low (active).
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pin_meta_ff <= {{3{1'b1}}, {(PIN_W-3){1'b0}}};
            pin_sync_ff <= {{3{1'b1}}, {(PIN_W-3){1'b0}}};
        end else begin
            pin_meta_ff <= {i_read_port_select_n, i_write_port_select_n, i_pll_disable_n,
                            i_addr, i_d, i_byte_lane_enable_n};
            pin_sync_ff <= pin_meta_ff;
        end
    end

    assign {rsel_n, wsel_n, strap_n, addr, din, lane_n} = pin_sync_ff;

    // ------------------------------------------------------------------
    // Beat phase and strap capture.
    // ------------------------------------------------------------------
    logic phase_ff;
    logic nxt_phase;
    logic [1:0] strap_cnt_ff;
    logic [1:0] nxt_strap_cnt;
    qrb_pkg::qrb_mode_t mode_ff;
    qrb_pkg::qrb_mode_t nxt_mode;
    logic k_rise;

    // The phase divider makes the positive-rise enable; the strap is caught
    // once after the synchroniser has settled and then held.
    always_comb begin
        nxt_phase = ~phase_ff;
        nxt_strap_cnt = strap_cnt_ff;
        nxt_mode = mode_ff;
        if (strap_cnt_ff != qrb_pkg::STRAP_SETTLE) begin
            nxt_strap_cnt = strap_cnt_ff + 2'h1;
        end
        if (strap_cnt_ff == qrb_pkg::STRAP_SETTLE - 2'h1) begin
            nxt_mode = strap_n ? qrb_pkg::QRB_MODE_PLL : qrb_pkg::QRB_MODE_LEGACY;
        end
    end

    // Registers of the phase and strap group.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            phase_ff <= 1'b0;
            strap_cnt_ff <= 2'h0;
            mode_ff <= qrb_pkg::QRB_MODE_PLL;
        end else begin
            phase_ff <= nxt_phase;
            strap_cnt_ff <= nxt_strap_cnt;
            mode_ff <= nxt_mode;
        end
    end

    assign k_rise = ~phase_ff;
    assign o_k_phase = phase_ff;

    // ------------------------------------------------------------------
    // Start arbitration.
    // ------------------------------------------------------------------
    logic rd_req;
    logic wr_req;
    logic start_rd;
    logic start_wr;
    logic [qrb_pkg::RD_AGE_DEPTH-1:0] rd_age_ff;
    logic [qrb_pkg::RD_AGE_DEPTH-1:0] nxt_rd_age;
    logic [qrb_pkg::WR_AGE_DEPTH-1:0] wr_age_ff;
    logic [qrb_pkg::WR_AGE_DEPTH-1:0] nxt_wr_age;

    // Selects are active low and looked at only on positive rises. A port that
    // started on the previous rise cannot start again, which also yields the
    // read-first alternation when both stay selected.
    always_comb begin
        rd_req = k_rise & ~rsel_n;
        wr_req = k_rise & ~wsel_n;
        start_rd = rd_req & ~rd_age_ff[1];
        start_wr = wr_req & ~wr_age_ff[1] & ~start_rd;
        nxt_rd_age = {rd_age_ff[qrb_pkg::RD_AGE_DEPTH-2:0], start_rd};
        nxt_wr_age = {wr_age_ff[qrb_pkg::WR_AGE_DEPTH-2:0], start_wr};
    end

    // Age shift registers: bit i is set i+1 cycles after a start.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_age_ff <= '0;
            wr_age_ff <= '0;
        end else begin
            rd_age_ff <= nxt_rd_age;
            wr_age_ff <= nxt_wr_age;
        end
    end

    // ------------------------------------------------------------------
    // Write path.
    // ------------------------------------------------------------------
    logic [qrb_pkg::ADDR_W-1:0] wa_ff;
    logic [qrb_pkg::ADDR_W-1:0] nxt_wa;
    logic [qrb_pkg::ADDR_W-1:0] wcommit_ff;
    logic [qrb_pkg::ADDR_W-1:0] nxt_wcommit;
    logic [qrb_pkg::BURST_W-1:0] wbuf_ff;
    logic [qrb_pkg::BURST_W-1:0] nxt_wbuf;
    logic [7:0] wmask_ff;
    logic [7:0] nxt_wmask;
    logic [1:0] wslot;
    logic wbeat;
    logic mem_we;
    logic [qrb_pkg::BURST_W-1:0] mem_wdata;
    logic [7:0] mem_wmask;

    // Words arrive on four beats after the start, one per beat, each with its
    // own lane enables; the fourth beat commits the whole burst at once so the
    // next write's words can reuse the buffer.
    always_comb begin
        nxt_wa = start_wr ? addr : wa_ff;
        nxt_wcommit = wr_age_ff[0] ? wa_ff : wcommit_ff;
        wbeat = |wr_age_ff[4:1];
        wslot = wr_age_ff[1] ? 2'h0 : wr_age_ff[2] ? 2'h1 : wr_age_ff[3] ? 2'h2 : 2'h3;
        nxt_wbuf = wbuf_ff;
        nxt_wmask = wmask_ff;
        if (wbeat) begin
            nxt_wbuf[wslot*qrb_pkg::WORD_W +: qrb_pkg::WORD_W] = din;
            nxt_wmask[wslot*2 +: 2] = ~lane_n;
        end
        mem_we = wr_age_ff[4];
        mem_wdata = nxt_wbuf;
        mem_wmask = nxt_wmask;
    end

    // Registers of the write path.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wa_ff <= '0;
            wcommit_ff <= '0;
            wbuf_ff <= '0;
            wmask_ff <= 8'h00;
        end else begin
            wa_ff <= nxt_wa;
            wcommit_ff <= nxt_wcommit;
            wbuf_ff <= nxt_wbuf;
            wmask_ff <= nxt_wmask;
        end
    end

    // ------------------------------------------------------------------
    // Storage.
    // ------------------------------------------------------------------
    logic [qrb_pkg::BURST_W-1:0] mem_rdata;

    // Reads are issued on the start beat with the address of that beat.
    qrb_mem u_mem (
        .i_clk(i_ref_clk),
        .i_we(mem_we),
        .i_waddr(wcommit_ff),
        .i_wdata(mem_wdata),
        .i_wmask(mem_wmask),
        .i_re(start_rd),
        .i_raddr(addr),
        .o_rdata(mem_rdata)
    );

    // ------------------------------------------------------------------
    // Read output path.
    // ------------------------------------------------------------------
    logic [qrb_pkg::BURST_W-1:0] rbuf_ff;
    logic [qrb_pkg::BURST_W-1:0] nxt_rbuf;
    logic [qrb_pkg::BURST_W-1:0] oshift_ff;
    logic [qrb_pkg::BURST_W-1:0] nxt_oshift;
    logic [1:0] ocnt_ff;
    logic [1:0] nxt_ocnt;
    logic [qrb_pkg::WORD_W-1:0] q_ff;
    logic [qrb_pkg::WORD_W-1:0] nxt_q;
    logic oe_ff;
    logic nxt_oe;
    logic oload;

    // A burst leaves lowest word first, one word per beat, after the latency
    // set by the strap. The driver floats only on a positive rise with nothing
    // left to send, so back-to-back bursts keep it on throughout.
    always_comb begin
        nxt_rbuf = rd_age_ff[0] ? mem_rdata : rbuf_ff;
        oload = (mode_ff == qrb_pkg::QRB_MODE_PLL) ?
                rd_age_ff[qrb_pkg::RD_LAT_PLL-2'h1] :
                rd_age_ff[qrb_pkg::RD_LAT_LEGACY-2'h1];
        nxt_oshift = oshift_ff;
        nxt_ocnt = ocnt_ff;
        nxt_q = q_ff;
        nxt_oe = oe_ff;
        if (oload) begin
            nxt_q = rbuf_ff[qrb_pkg::WORD_W-1:0];
            nxt_oshift = rbuf_ff >> qrb_pkg::WORD_W;
            nxt_ocnt = qrb_pkg::OUT_WORDS_LEFT;
            nxt_oe = 1'b1;
        end else if (ocnt_ff != 2'h0) begin
            nxt_q = oshift_ff[qrb_pkg::WORD_W-1:0];
            nxt_oshift = oshift_ff >> qrb_pkg::WORD_W;
            nxt_ocnt = ocnt_ff - 2'h1;
        end else if (k_rise) begin
            nxt_oe = 1'b0;
        end
    end

    // Output registers launch each read word.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rbuf_ff <= '0;
            oshift_ff <= '0;
            ocnt_ff <= 2'h0;
            q_ff <= qrb_pkg::Q_RESET;
            oe_ff <= 1'b0;
        end else begin
            rbuf_ff <= nxt_rbuf;
            oshift_ff <= nxt_oshift;
            ocnt_ff <= nxt_ocnt;
            q_ff <= nxt_q;
            oe_ff <= nxt_oe;
        end
    end

    assign o_q = q_ff;
    assign o_q_oe = oe_ff;

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    a_rd_lat_pll: assert property (start_rd && mode_ff == qrb_pkg::QRB_MODE_PLL |->
        !oload ##1 !oload ##1 !oload ##1 oload ##1 o_q_oe) else $error("pll read latency wrong");
    a_rd_lat_legacy: assert property (start_rd && mode_ff == qrb_pkg::QRB_MODE_LEGACY |->
        ##3 (o_q_oe && o_q == $past(rbuf_ff[qrb_pkg::WORD_W-1:0]))) else $error("legacy latency");
    a_start_on_rise: assert property ((start_rd || start_wr) |-> !phase_ff)
        else $error("start off the positive rise");
    a_rd_no_repeat: assert property (start_rd |-> ##2 !start_rd)
        else $error("read started on consecutive rises");
    a_wr_no_repeat: assert property (start_wr |-> ##2 !start_wr)
        else $error("write started on consecutive rises");
    a_both_read_first: assert property (rd_req && wr_req && !rd_age_ff[1] |->
        start_rd && !start_wr ##2 (!wr_req || start_wr)) else $error("arbitration order wrong");
    a_burst_four: assert property (oload && ocnt_ff == 2'h0 |=> o_q_oe[*4])
        else $error("burst shorter than four words");
    a_wr_commit: assert property (start_wr |-> ##5 (mem_we && wcommit_ff == $past(addr, 5)))
        else $error("write commit late or wrong address");
    a_oe_release: assert property ($fell(o_q_oe) |-> $past(ocnt_ff) == 2'h0 && $past(k_rise))
        else $error("outputs floated mid burst");

    c_read_pll: cover property (start_rd && mode_ff == qrb_pkg::QRB_MODE_PLL ##4 start_rd);
    c_write_stream: cover property (start_wr ##4 start_wr ##4 start_wr);
    c_both_selected: cover property (start_rd && wr_req ##2 start_wr);

endmodule : qrb_ports

//--- test/qrb_ctrl_model.sv
/*
 * Behavioural memory controller on the far side of the burst SRAM ports.
 * Assumes the bench calls its tasks one at a time and that o_k_phase is seen.
 */
`timescale 1ns/100ps

module qrb_ctrl_model (
    input wire logic i_clk,
    input wire logic i_k_phase,
    input wire logic [qrb_pkg::WORD_W-1:0] i_q,
    input wire logic i_q_oe,
    output logic o_rps_n,
    output logic o_wps_n,
    output logic [qrb_pkg::ADDR_W-1:0] o_addr,
    output logic [qrb_pkg::WORD_W-1:0] o_d,
    output logic [qrb_pkg::LANES-1:0] o_lanes_n
);
    // Idle levels: both ports deselected.
    initial begin
        o_rps_n = 1'h1;
        o_wps_n = 1'h1;
        o_addr = 20'h00000;
        o_d = 18'h00000;
        o_lanes_n = 2'h3;
    end

    // Waits for a falling edge just before a positive clock rise.
    task automatic wait_k();
        do @(negedge i_clk); while (i_k_phase !== 1'h0);
    endtask : wait_k

    // Writes one burst; dup holds the select for a second rise at address b.
    task automatic write_burst(input logic [19:0] a, input logic [71:0] w,
            input logic [7:0] ln, input logic dup, input logic [19:0] b);
        wait_k();
        o_wps_n = 1'h0;
        o_addr = a;
        for (int k = 1; k < 7; k++) begin
            @(negedge i_clk);
            o_wps_n = !(dup && k < 3);
            o_addr = (dup && k == 2) ? b : ~o_addr;
            if (k >= 2 && k <= 5) begin
                o_d = w[18*(k-2) +: 18];
                o_lanes_n = ln[2*(k-2) +: 2];
            end else begin
                o_d = ~o_d;
                o_lanes_n = ~o_lanes_n;
            end
        end
    endtask : write_burst

    // Reads one burst and records the output enable around it.
    task automatic read_burst(input logic [19:0] a, input logic dup,
            input logic [19:0] b, input int lat,
            output logic [71:0] q, output logic [5:0] oe);
        wait_k();
        o_rps_n = 1'h0;
        o_addr = a;
        for (int k = 1; k <= lat + 9; k++) begin
            @(negedge i_clk);
            o_rps_n = !(dup && k < 3);
            o_addr = (dup && k == 2) ? b : ~o_addr;
            o_d = ~o_d;
            if (k >= lat + 3 && k <= lat + 6) begin
                q[18*(k-lat-3) +: 18] = i_q;
            end
            if (k >= lat + 2 && k <= lat + 6) begin
                oe[k-lat-2] = i_q_oe;
            end
            if (k == lat + 9) begin
                oe[5] = i_q_oe;
            end
        end
    endtask : read_burst
endmodule : qrb_ctrl_model

//--- test/tb_top.sv
/*
 * Self-checking bench for the burst SRAM port logic.
 * Assumes the controller model in qrb_ctrl_model.sv drives the ports.
 */
`timescale 1ns/100ps

module tb_top;
    logic i_ref_clk = 1'h0;
    logic i_rstn = 1'h0;
    logic i_pll_disable_n = 1'h1;
    logic rps_n;
    logic wps_n;
    logic [19:0] addr;
    logic [17:0] d;
    logic [1:0] lanes_n;
    logic k_phase;
    logic [17:0] q_pin;
    logic q_oe;
    logic [71:0] q;
    logic [5:0] oe;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    localparam logic [71:0] D1 = 72'h123456789ABCDEF012;
    localparam logic [71:0] D2 = 72'hFEDCBA9876543210FE;
    localparam logic [71:0] D3 = 72'h0F1E2D3C4B5A697887;
    localparam logic [71:0] D4 = 72'hA5A5A5C3C3C3969696;

    // ----------------------------------------------------------------
    // Clock, design and controller.
    // ----------------------------------------------------------------
    // The clock toggles every 20 ns, giving a 40 ns period.
    always #20 i_ref_clk = ~i_ref_clk;

    qrb_ports qrb_ports_i (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_read_port_select_n(rps_n),
        .i_write_port_select_n(wps_n),
        .i_addr(addr),
        .i_d(d),
        .i_byte_lane_enable_n(lanes_n),
        .i_pll_disable_n(i_pll_disable_n),
        .o_k_phase(k_phase),
        .o_q(q_pin),
        .o_q_oe(q_oe)
    );

    qrb_ctrl_model qrb_ctrl_model_i (
        .i_clk(i_ref_clk),
        .i_k_phase(k_phase),
        .i_q(q_pin),
        .i_q_oe(q_oe),
        .o_rps_n(rps_n),
        .o_wps_n(wps_n),
        .o_addr(addr),
        .o_d(d),
        .o_lanes_n(lanes_n)
    );

    // ----------------------------------------------------------------
    // Checking and closing.
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [71:0] seen,
            input logic [71:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    // A hang is cut short after far more cycles than the tests need.
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            stop_test();
        end
    end

    // Expected burst after a masked write over old contents.
    function automatic logic [71:0] merge(input logic [71:0] old,
            input logic [71:0] nw, input logic [7:0] ln);
        merge = old;
        for (int k = 0; k < 4; k++) begin
            if (!ln[2*k]) merge[18*k +: 9] = nw[18*k +: 9];
            if (!ln[2*k+1]) merge[18*k+9 +: 9] = nw[18*k+9 +: 9];
        end
    endfunction : merge

    // ----------------------------------------------------------------
    // Scenarios.
    // ----------------------------------------------------------------
    task automatic do_reset(input logic strap);
        @(negedge i_ref_clk);
        i_pll_disable_n = strap;
        i_rstn = 1'h0;
        repeat (8) @(negedge i_ref_clk);
        check("oe in reset", {71'h0, q_oe}, 72'h0);
        check("q in reset", {54'h0, q_pin}, 72'h0);
        check("k_phase in reset", {71'h0, k_phase}, 72'h0);
        i_rstn = 1'h1;
        @(negedge i_ref_clk);
        check("k_phase after reset", {71'h0, k_phase}, 72'h1);
        repeat (3) @(negedge i_ref_clk);
        $display("reset done");
    endtask : do_reset

    task automatic t_basic(input int lat);
        qrb_ctrl_model_i.write_burst(20'h00010, D1, 8'h00, 1'h0, 20'h00000);
        qrb_ctrl_model_i.read_burst(20'h00010, 1'h0, 20'h00000, lat, q, oe);
        check("burst data", q, D1);
        check("oe timing", {66'h0, oe}, {66'h0, 6'h1E});
        $display("t_basic done");
    endtask : t_basic

    task automatic t_lanes();
        qrb_ctrl_model_i.write_burst(20'h00010, D2, 8'h6C, 1'h0, 20'h00000);
        qrb_ctrl_model_i.read_burst(20'h00010, 1'h0, 20'h00000, 3, q, oe);
        check("lane merge", q, merge(D1, D2, 8'h6C));
        $display("t_lanes done");
    endtask : t_lanes

    task automatic t_wr_b2b();
        qrb_ctrl_model_i.write_burst(20'h00020, D3, 8'h00, 1'h0, 20'h00000);
        qrb_ctrl_model_i.write_burst(20'h00030, D4, 8'h00, 1'h1, 20'h00020);
        qrb_ctrl_model_i.read_burst(20'h00020, 1'h0, 20'h00000, 3, q, oe);
        check("dropped write", q, D3);
        qrb_ctrl_model_i.read_burst(20'h00030, 1'h0, 20'h00000, 3, q, oe);
        check("first write", q, D4);
        $display("t_wr_b2b done");
    endtask : t_wr_b2b

    task automatic t_rd_b2b();
        qrb_ctrl_model_i.read_burst(20'h00030, 1'h1, 20'h00020, 3, q, oe);
        check("first read", q, D4);
        check("ignored read oe", {66'h0, oe}, {66'h0, 6'h1E});
        $display("t_rd_b2b done");
    endtask : t_rd_b2b

    // Main sequence: PLL strap first, then the legacy latency.
    initial begin
        do_reset(1'h1);
        t_basic(3);
        t_lanes();
        t_wr_b2b();
        t_rd_b2b();
        do_reset(1'h0);
        t_basic(2);
        stop_test();
    end
endmodule : tb_top
